// [hri_consts.svh]
// register offsets, field positions and reset values of the host register block
// assumes byte addresses on a 25-bit host address
`ifndef HRI_CONSTS_SVH
`define HRI_CONSTS_SVH

// top-level address ranges
`define HRI_CORE_TOP 25'h007FFFF
`define HRI_GLB_LO 25'h0108000
`define HRI_GLB_HI 25'h0108FFF
`define HRI_SDR_LO 25'h1000000
`define HRI_SDR_HI 25'h1FFFFFF

// packet-core registers
`define HRI_PEND_OFS 25'h0000000
`define HRI_MASK_OFS 25'h0000004
`define HRI_CWLO_OFS 25'h0000008
`define HRI_CWHI_OFS 25'h000000C
`define HRI_MAC_OFS 25'h0000010
`define HRI_TXP_PAGE 17'h00001
`define HRI_JBP_PAGE 17'h00002

// global registers
`define HRI_GSTAT_OFS 25'h0108010
`define HRI_GMASK_OFS 25'h0108014
`define HRI_GIRQ_BIT 24

// reset values
`define HRI_MASK_RST 32'hFFFFFFFF
`define HRI_GEN_RST 1'b0

`endif

// [hri_pkg.sv]
// types shared by the host register block
// assumes the constants header is included by the modules
package hri_pkg;
    typedef enum logic [1:0] {
        HRI_RG_CORE,
        HRI_RG_GLOBAL,
        HRI_RG_SDRAM,
        HRI_RG_RSVD
    } hri_region_t;
endpackage

// [hri_w1c_bank.sv]
// sticky flag vector: set by hardware pulses, cleared by a mask
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module hri_w1c_bank #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // set and clear
    input wire logic [W-1:0] set_vec,
    input wire logic [W-1:0] clr_vec,
    // flags
    output logic [W-1:0] flags_q
);
    // set wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_vec) | set_vec;
        end
    end
endmodule

// [hri_top.sv]
// host register and interrupt block on an Avalon-MM slave
// assumes event pulses on mclk, straps as asynchronous pins
// Behaviour
// R1: host reads receive signaling values of the port after acknowledging a change.
// R2: pending register holds one transmit signaling change bit per port, write 1 clears.
// R3: per-port transmit signaling registers flag changed timeslots, write 1 clears.
// R4: control-word change flags per bundle in lower and upper registers, write 1 clears.
// R5: host clears control-word summary bit first, then reads classifier status.
// R6: pending register has one jitter-buffer underflow bit per port, write 1 clears.
// R7: per-port underflow registers show which buffers underran, write 1 clears.
// R8: MAC summary pending bit cleared by writing 1, before reading MAC status.
// R9: reading MAC event status returns events and clears the bits read.
// R10: a masked pending bit fires the interrupt as soon as its mask clears.
// R11: host should clear stale pending bits before unmasking a source.
// R12: accesses are 2 or 4 bytes wide, chosen by a static strap.
// R13: addresses are multiples of 2 in 16-bit mode, of 4 in 32-bit mode.
// R14: big-endian byte order, most significant byte at lowest address; the code puts bits 15:0 at offset 0 and bits 31:16 at offset 2.
// R15: narrow elements are right-aligned from bit 0, upper bits unused.
// R16: elements under 16 bits keep the same bit positions in both modes.
// R17: wider elements need two 16-bit accesses, low half first, then upper.
// R18: serial host mode always uses 32-bit addressing whatever the width strap.
// R19: decode core, global and SDRAM ranges; everything else is reserved.
// R20: a pending bit stays set until written with 1; writing 0 keeps it.
// R21: all mask bits reset masked; writing 0 enables the pending source.
// R22: core interrupts reach the pin only while the global enable is 1.
// R23: in 16-bit mode upper strobe writes bits 15:8, lower writes 7:0.
// R24: interrupt asserted while any unmasked pending bit is set and enabled.
`timescale 1ns/1ps
`include "hri_consts.svh"
module hri_top #(
    parameter int P = 8,
    parameter int TS = 32,
    parameter int MACW = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // avalon slave
    input wire logic [24:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // straps
    input wire logic bus_width_strap,
    input wire logic spi_mode_n,
    // event pulses
    input wire logic [P*TS-1:0] tx_sig_event,
    input wire logic [P*TS-1:0] jitter_event,
    input wire logic [63:0] control_word_event,
    input wire logic [MACW-1:0] mac_event,
    // interrupt
    output logic irq
);
    localparam int PW = 2 * P + 2;
    localparam int PI = (P > 1) ? $clog2(P) : 1;
    localparam int CW_BIT = 2 * P;
    localparam int MAC_BIT = 2 * P + 1;

    logic [1:0] wid_sync_q;
    logic [1:0] spi_sync_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] mac_seen_q;
    logic [31:0] mask_q;
    logic en_q;
    logic irq_q;
    logic mode32;
    logic req;
    logic wr_fire;
    logic rd_fire;
    logic misalign;
    hri_pkg::hri_region_t region;
    logic [24:0] a_w;
    logic [PI-1:0] port;
    logic hit_tx;
    logic hit_jb;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [31:0] w1c;
    logic [31:0] rword;
    logic [31:0] rmask;
    logic [31:0] rdata_d;
    logic [PW-1:0] pend_q;
    logic [PW-1:0] pend_set;
    logic [PW-1:0] pend_clr;
    logic [31:0] cwlo_q;
    logic [31:0] cwhi_q;
    logic [MACW-1:0] mac_q;
    logic [MACW-1:0] mac_clr;
    logic [TS-1:0] tx_q [P];
    logic [TS-1:0] jb_q [P];
    logic irq_src;

    // strap synchronisers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wid_sync_q <= 2'h0;
            spi_sync_q <= 2'h3;
        end else begin
            wid_sync_q <= {wid_sync_q[0], bus_width_strap};
            spi_sync_q <= {spi_sync_q[0], spi_mode_n};
        end
    end

    // R12 R18: width select, serial mode forces 32
    assign mode32 = wid_sync_q[1] | ~spi_sync_q[1];

    // one wait cycle per access
    assign req = avs_read | avs_write;
    assign wr_fire = avs_write & ~wait_q;
    assign rd_fire = avs_read & ~wait_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // R13: alignment to access width
    assign misalign = mode32 ? (avs_address[1:0] != 2'h0) : avs_address[0];

    // R19: top-level decode
    always_comb begin
        if (avs_address <= `HRI_CORE_TOP) begin
            region = hri_pkg::HRI_RG_CORE;
        end else if (avs_address >= `HRI_GLB_LO && avs_address <= `HRI_GLB_HI) begin
            region = hri_pkg::HRI_RG_GLOBAL;
        end else if (avs_address >= `HRI_SDR_LO) begin
            region = hri_pkg::HRI_RG_SDRAM;
        end else begin
            region = hri_pkg::HRI_RG_RSVD;
        end
    end

    assign a_w = {avs_address[24:2], 2'h0};
    assign port = avs_address[2 +: PI];
    assign hit_tx = (avs_address[24:8] == `HRI_TXP_PAGE) && (avs_address[7:2] < 6'(P));
    assign hit_jb = (avs_address[24:8] == `HRI_JBP_PAGE) && (avs_address[7:2] < 6'(P));

    // R14 R23: lane placement, halves in 16-bit mode
    always_comb begin
        if (mode32) begin
            wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
            wdat = avs_writedata;
            rmask = 32'hFFFFFFFF;
        end else if (avs_address[1]) begin
            wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}, 16'h0000};
            wdat = {avs_writedata[15:0], 16'h0000};
            rmask = 32'hFFFF0000;
        end else begin
            wmask = {16'h0000, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
            wdat = {16'h0000, avs_writedata[15:0]};
            rmask = 32'h0000FFFF;
        end
    end

    assign w1c = (wr_fire && !misalign && region != hri_pkg::HRI_RG_RSVD
                  && region != hri_pkg::HRI_RG_SDRAM) ? (wdat & wmask) : 32'h00000000;

    // R2 R6 R8: summary pending bits per source
    always_comb begin
        pend_set = '0;
        for (int p = 0; p < P; p++) begin
            pend_set[p] = |tx_sig_event[p*TS +: TS];
            pend_set[P + p] = |jitter_event[p*TS +: TS];
        end
        pend_set[CW_BIT] = |control_word_event;
        pend_set[MAC_BIT] = |mac_event;
    end
    // R20: only a written 1 clears
    assign pend_clr = (a_w == `HRI_PEND_OFS) ? w1c[PW-1:0] : '0;

    hri_w1c_bank #(.W(PW)) u_pend (
        .mclk(mclk),
        .rst(rst),
        .set_vec(pend_set),
        .clr_vec(pend_clr),
        .flags_q(pend_q)
    );

    // R4: control-word change per bundle
    hri_w1c_bank #(.W(32)) u_cwlo (
        .mclk(mclk),
        .rst(rst),
        .set_vec(control_word_event[31:0]),
        .clr_vec((a_w == `HRI_CWLO_OFS) ? w1c : 32'h00000000),
        .flags_q(cwlo_q)
    );
    hri_w1c_bank #(.W(32)) u_cwhi (
        .mclk(mclk),
        .rst(rst),
        .set_vec(control_word_event[63:32]),
        .clr_vec((a_w == `HRI_CWHI_OFS) ? w1c : 32'h00000000),
        .flags_q(cwhi_q)
    );

    // R9: clear only the bits that the read returned
    assign mac_clr = (rd_fire && a_w == `HRI_MAC_OFS) ? mac_seen_q[MACW-1:0] : '0;
    hri_w1c_bank #(.W(MACW)) u_mac (
        .mclk(mclk),
        .rst(rst),
        .set_vec(mac_event),
        .clr_vec(mac_clr),
        .flags_q(mac_q)
    );

    // R3 R7: per-port timeslot and buffer flags
    for (genvar p = 0; p < P; p++) begin : g_port
        hri_w1c_bank #(.W(TS)) u_tx (
            .mclk(mclk),
            .rst(rst),
            .set_vec(tx_sig_event[p*TS +: TS]),
            .clr_vec((hit_tx && port == PI'(p)) ? w1c[TS-1:0] : '0),
            .flags_q(tx_q[p])
        );
        hri_w1c_bank #(.W(TS)) u_jb (
            .mclk(mclk),
            .rst(rst),
            .set_vec(jitter_event[p*TS +: TS]),
            .clr_vec((hit_jb && port == PI'(p)) ? w1c[TS-1:0] : '0),
            .flags_q(jb_q[p])
        );
    end

    // R21: masks reset masked, byte-wise writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_q <= `HRI_MASK_RST;
        end else if (wr_fire && !misalign && a_w == `HRI_MASK_OFS) begin
            mask_q <= (mask_q & ~wmask) | (wdat & wmask);
        end
    end

    // R22: global packet-core enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_q <= `HRI_GEN_RST;
        end else if (wr_fire && !misalign && a_w == `HRI_GMASK_OFS
                     && wmask[`HRI_GIRQ_BIT]) begin
            en_q <= wdat[`HRI_GIRQ_BIT];
        end
    end

    // R10 R24: unmasked pending sources
    assign irq_src = |(pend_q & ~mask_q[PW-1:0]);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_src & en_q;
        end
    end
    assign irq = irq_q;

    // register word at the address, sdram and reserved read zero
    always_comb begin
        rword = 32'h00000000;
        if (hit_tx) begin
            rword[TS-1:0] = tx_q[port];
        end else if (hit_jb) begin
            rword[TS-1:0] = jb_q[port];
        end else begin
            unique case (a_w)
                `HRI_PEND_OFS: rword[PW-1:0] = pend_q;
                `HRI_MASK_OFS: rword = mask_q;
                `HRI_CWLO_OFS: rword = cwlo_q;
                `HRI_CWHI_OFS: rword = cwhi_q;
                `HRI_MAC_OFS: rword[MACW-1:0] = mac_q;
                `HRI_GSTAT_OFS: rword[`HRI_GIRQ_BIT] = irq_src;
                `HRI_GMASK_OFS: rword[`HRI_GIRQ_BIT] = en_q;
                default: rword = 32'h00000000;
            endcase
        end
    end

    // R15 R16 R17: halves right-aligned in 16-bit mode
    always_comb begin
        if (misalign || region == hri_pkg::HRI_RG_RSVD || region == hri_pkg::HRI_RG_SDRAM) begin
            rdata_d = 32'h00000000;
        end else if (mode32) begin
            rdata_d = rword;
        end else if (avs_address[1]) begin
            rdata_d = {16'h0000, rword[31:16]};
        end else begin
            rdata_d = {16'h0000, rword[15:0]};
        end
    end

    // read data and shown MAC bits captured in the wait cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
            mac_seen_q <= 32'h00000000;
        end else if (avs_read && wait_q) begin
            rdata_q <= rdata_d;
            mac_seen_q <= misalign ? 32'h00000000 : (rword & rmask);
        end
    end
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_irq_follows: assert property (1 |=> irq_q == $past(irq_src && en_q)) // R24
        else $error("irq does not follow unmasked pending");
    chk_unmask_fires: assert property (en_q // R10
        && |($past(mask_q[PW-1:0]) & ~mask_q[PW-1:0] & pend_q) |=> irq_q)
        else $error("unmask of pending bit did not raise irq");
    chk_pend_sticky: assert property (1 |=> (($past(pend_q) & ~$past(pend_clr)) & ~pend_q) == '0) // R20
        else $error("pending bit lost without write of 1");
    chk_mask_write_only: assert property (!$stable(mask_q) |-> $past(wr_fire)) // R21
        else $error("mask changed without a write");
    chk_global_gate: assert property (!en_q |=> !irq_q) // R22
        else $error("irq while global enable is off");
    chk_mac_read_clear: assert property (mac_clr != '0 && mac_event == '0 // R9
        |=> (mac_q & $past(mac_clr)) == '0)
        else $error("MAC status bits survive their read");
    chk_wait_one: assert property (req && wait_q ##1 req |-> !wait_q ##1 wait_q) // R12
        else $error("access not answered after one wait cycle");
    chk_misalign_drop: assert property (wr_fire && misalign |=> $stable(mask_q)) // R13
        else $error("misaligned write took effect");
    chk_half_upper_zero: assert property (avs_read && wait_q && !mode32 // R15
        |=> rdata_q[31:16] == 16'h0000)
        else $error("16-bit read has upper bits set");
    chk_spi_forces32: assert property (!spi_sync_q[1] |-> mode32) // R18
        else $error("serial mode not in 32-bit addressing");

    cov_irq_raised: cover property ($rose(irq_q));
    cov_mac_read: cover property (mac_clr != '0);
    cov_half_write: cover property (wr_fire && !mode32 && avs_address[1]);
endmodule

// [hri_host_model.sv]
// host processor model: avalon master with blocking read and write tasks
// assumes the slave answers through waitrequest on rising mclk edges
`timescale 1ns/1ps
module hri_host_model (
    // clock
    input wire logic mclk,
    // avalon master
    output logic [24:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 25'h0000000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
    end
    task automatic wr(input logic [24:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_writedata <= ~d;
    endtask
    task automatic rd(input logic [24:0] a, output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_byteenable <= 4'hF;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule

// [test_hri_top.sv]
// self-checking bench for the host register block
// assumes the host model above and the design's one-wait-cycle answer
`timescale 1ns/1ps
module test_hri_top;
    logic mclk;
    logic rst;
    logic [24:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic bus_width_strap;
    logic spi_mode_n;
    logic [255:0] tx_sig_event;
    logic [255:0] jitter_event;
    logic [63:0] control_word_event;
    logic [15:0] mac_event;
    logic irq;
    int n_mismatch;
    int checked;

    hri_top hri_top_inst (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_width_strap(bus_width_strap),
        .spi_mode_n(spi_mode_n), .tx_sig_event(tx_sig_event), .jitter_event(jitter_event),
        .control_word_event(control_word_event), .mac_event(mac_event), .irq(irq));
    hri_host_model hri_host_model_inst (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [24:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        hri_host_model_inst.rd(a, q);
        chk(q & m, e);
    endtask
    task automatic wr(input logic [24:0] a, input logic [31:0] d, input logic [3:0] be);
        hri_host_model_inst.wr(a, d, be);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        chk({31'h00000000, irq}, {31'h00000000, e});
    endtask
    // one-cycle event pulse of the chosen source
    task automatic ev(input int k, input int b);
        @(posedge mclk);
        case (k)
            0: tx_sig_event[b] <= 1'b1;
            1: jitter_event[b] <= 1'b1;
            2: control_word_event[b] <= 1'b1;
            default: mac_event[b] <= 1'b1;
        endcase
        @(posedge mclk);
        tx_sig_event <= '0;
        jitter_event <= '0;
        control_word_event <= '0;
        mac_event <= '0;
    endtask
    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        test_done;
    end

    initial begin
        n_mismatch = 0;
        checked = 0;
        rst = 1'b1;
        bus_width_strap = 1'b1;
        spi_mode_n = 1'b1;
        tx_sig_event = '0;
        jitter_event = '0;
        control_word_event = '0;
        mac_event = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk({31'h00000000, avs_waitrequest}, 32'h00000001);
        chk(avs_readdata, 32'h00000000);
        rc(25'h0000004, 32'h0003FFFF, 32'h0003FFFF);
        rc(25'h0108014, 32'hFFFFFFFF, 32'h00000000);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000000);
        // transmit signaling, port 2 timeslot 5
        ev(0, 69);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000004);
        rc(25'h0000108, 32'hFFFFFFFF, 32'h00000020);
        wr(25'h0000000, 32'h00000000, 4'hF);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000004);
        wr(25'h0000108, 32'h00000020, 4'hF);
        rc(25'h0000108, 32'hFFFFFFFF, 32'h00000000);
        wr(25'h0000000, 32'h00000004, 4'hF);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000000);
        // jitter underflow port 1 buffer 3, masked then unmasked
        ev(1, 35);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000200);
        rc(25'h0000204, 32'hFFFFFFFF, 32'h00000008);
        wr(25'h0108014, 32'h01000000, 4'hF);
        irq_is(1'b0);
        wr(25'h0000004, 32'hFFFFFDFF, 4'hF);
        irq_is(1'b1);
        rc(25'h0108010, 32'h01000000, 32'h01000000);
        wr(25'h0108014, 32'h00000000, 4'hF);
        irq_is(1'b0);
        wr(25'h0108014, 32'h01000000, 4'hF);
        irq_is(1'b1);
        wr(25'h0000204, 32'h00000008, 4'hF);
        rc(25'h0000204, 32'hFFFFFFFF, 32'h00000000);
        wr(25'h0000000, 32'h00000200, 4'hF);
        irq_is(1'b0);
        // control word, bundles 3 and 40
        ev(2, 3);
        ev(2, 40);
        wr(25'h0000000, 32'h00010000, 4'hF);
        rc(25'h0000008, 32'hFFFFFFFF, 32'h00000008);
        rc(25'h000000C, 32'hFFFFFFFF, 32'h00000100);
        wr(25'h0000008, 32'h00000008, 4'hF);
        wr(25'h000000C, 32'h00000100, 4'hF);
        rc(25'h000000C, 32'hFFFFFFFF, 32'h00000000);
        // mac source 5
        ev(3, 5);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00020000);
        wr(25'h0000000, 32'h00020000, 4'hF);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000000);
        rc(25'h0000010, 32'hFFFFFFFF, 32'h00000020);
        rc(25'h0000010, 32'hFFFFFFFF, 32'h00000000);
        // decode, reserved ranges, alignment and lanes
        wr(25'h0080000, 32'hFFFFFFFF, 4'hF);
        rc(25'h0080000, 32'hFFFFFFFF, 32'h00000000);
        rc(25'h1000000, 32'hFFFFFFFF, 32'h00000000);
        rc(25'h0000006, 32'hFFFFFFFF, 32'h00000000);
        wr(25'h0000005, 32'h00000000, 4'hF);
        rc(25'h0000004, 32'h0003FFFF, 32'h0003FDFF);
        wr(25'h0000004, 32'h00000000, 4'h1);
        rc(25'h0000004, 32'h0003FFFF, 32'h0003FD00);
        wr(25'h0108014, 32'h00000000, 4'hF);
        wr(25'h0000004, 32'hFFFFFFFF, 4'hF);
        // 16-bit mode
        bus_width_strap <= 1'b0;
        repeat (4) @(posedge mclk);
        ev(2, 1);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00000000);
        rc(25'h0000002, 32'hFFFFFFFF, 32'h00000001);
        rc(25'h0000001, 32'hFFFFFFFF, 32'h00000000);
        wr(25'h0000004, 32'h00000000, 4'h2);
        rc(25'h0000004, 32'hFFFFFFFF, 32'h000000FF);
        rc(25'h0000008, 32'hFFFFFFFF, 32'h00000002);
        spi_mode_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rc(25'h0000000, 32'hFFFFFFFF, 32'h00010000);
        spi_mode_n <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(25'h0000002, 32'h00000001, 4'h1);
        rc(25'h0000002, 32'hFFFFFFFF, 32'h00000000);
        test_done;
    end
endmodule
